// file: rtl/tx_capture_pkg.sv
// Constants, register map and types for the transmit input capture stage
package tx_capture_pkg;

    localparam int unsigned AXI_ADDR_W = 4;
    localparam int unsigned AXI_DATA_W = 32;

    localparam logic [3:0] CTRL_OFFSET   = 4'h0;
    localparam logic [3:0] STATUS_OFFSET = 4'h4;
    localparam logic [3:0] COUNT_OFFSET  = 4'h8;

    localparam int unsigned CTRL_W                  = 4;
    localparam int unsigned CTRL_HOST_MODE_BIT      = 0;
    localparam int unsigned CTRL_CAPTURE_RISING_BIT = 1;
    localparam int unsigned CTRL_DUAL_RAIL_BIT      = 2;
    localparam int unsigned CTRL_HOST_TX_EN_BIT     = 3;
    localparam logic [3:0]  CTRL_RESET              = 4'h4;

    localparam int unsigned STAT_W               = 3;
    localparam int unsigned STAT_TX_ACTIVE_BIT   = 0;
    localparam int unsigned STAT_OVERFLOW_BIT    = 1;
    localparam int unsigned STAT_EDGE_RISING_BIT = 2;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam int unsigned PIN_W    = 5;
    localparam int unsigned PIN_ON   = 0;
    localparam int unsigned PIN_CLK  = 1;
    localparam int unsigned PIN_EDGE = 2;
    localparam int unsigned PIN_POS  = 3;
    localparam int unsigned PIN_NEG  = 4;

    localparam int unsigned RAIL_W    = 2;
    localparam int unsigned BUF_DEPTH = 2;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_RESP = 2'b10
    } bus_state_e;

endpackage : tx_capture_pkg

// file: rtl/rail_skid_buffer.sv
// Shift-style buffer whose head entry is a flip-flop, so outputs are registered
`timescale 1ns/1ps
`default_nettype none
module rail_skid_buffer #(
    parameter int unsigned WIDTH = tx_capture_pkg::RAIL_W,
    parameter int unsigned DEPTH = tx_capture_pkg::BUF_DEPTH
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output var  logic             in_ready,
    output var  logic             out_valid,
    output var  logic [WIDTH-1:0] out_data,
    input  wire logic             out_ready
);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [DEPTH-1:0] vld_q;
    logic [DEPTH-1:0] vld_d;
    logic [DEPTH-1:0] shift_vld;
    logic [WIDTH-1:0] mem_d [DEPTH];
    wire              pop  = vld_q[0] & out_ready;
    wire              push = in_valid & ~vld_q[DEPTH-1];

    // Entry i takes its upper neighbour on a pop, then the input lands in the first free slot
    genvar i;
    generate
        for (i = 0; i < DEPTH; i++) begin : g_entry
            wire              up_vld  = (i + 1 < DEPTH) ? vld_q[(i+1)%DEPTH] : 1'b0;
            wire [WIDTH-1:0]  up_data = (i + 1 < DEPTH) ? mem_q[(i+1)%DEPTH] : '0;
            wire              below   = (i == 0) ? 1'b1 : shift_vld[(i+DEPTH-1)%DEPTH];
            wire              wr_here;
            assign shift_vld[i] = pop ? up_vld : vld_q[i];
            assign wr_here      = push & ~shift_vld[i] & below;
            assign vld_d[i]     = shift_vld[i] | wr_here;
            assign mem_d[i]     = wr_here ? in_data : (pop ? up_data : mem_q[i]);
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    mem_q[i] <= '0;
                end else begin
                    mem_q[i] <= mem_d[i];
                end
            end
        end
    endgenerate

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            vld_q <= '0;
        end else begin
            vld_q <= vld_d;
        end
    end

    assign out_valid = vld_q[0];
    assign out_data  = mem_q[0];
    // Full is honest: no push while the last slot holds a word, even on a pop
    assign in_ready  = ~vld_q[DEPTH-1];

endmodule : rail_skid_buffer
`default_nettype wire

// file: rtl/tx_input_capture_ctrl.sv
// Transmit input capture, transmitter on/off control and AXI4-Lite register slave
//
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module tx_input_capture_ctrl #(
    parameter int unsigned ADDR_W = tx_capture_pkg::AXI_ADDR_W,
    parameter int unsigned DEPTH  = tx_capture_pkg::BUF_DEPTH
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // AXI4-Lite slave
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output var  logic              s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output var  logic              s_axi_wready,
    output var  logic [1:0]        s_axi_bresp,
    output var  logic              s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output var  logic              s_axi_arready,
    output var  logic [31:0]       s_axi_rdata,
    output var  logic [1:0]        s_axi_rresp,
    output var  logic              s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Terminal-side pins
    input  wire logic              transmitter_on_input,
    input  wire logic              tx_line_clock,
    input  wire logic              tx_capture_edge_select,
    input  wire logic              tx_positive_rail_data,
    input  wire logic              tx_negative_rail_data,
    // Line outputs, enable high while driven
    output var  logic              line_out_tip,
    output var  logic              line_out_tip_oe,
    output var  logic              line_out_ring,
    output var  logic              line_out_ring_oe,
    // Serial clock handed to the host interface in host mode
    output var  logic              host_serial_clock,
    // Captured rail stream
    output var  logic              cap_valid,
    output var  logic              cap_pos_rail,
    output var  logic              cap_neg_rail,
    input  wire logic              cap_ready
);

    function automatic logic addr_is(input logic [ADDR_W-1:0] addr, input logic [3:0] off);
        addr_is = (addr[ADDR_W-1:2] == off[ADDR_W-1:2]);
    endfunction : addr_is

    // ---------------- Pin synchronisers ----------------
    logic [tx_capture_pkg::PIN_W-1:0] pin_s1_q;
    logic [tx_capture_pkg::PIN_W-1:0] pin_s2_q;
    logic                             clk_s3_q;
    wire  [tx_capture_pkg::PIN_W-1:0] pin_raw = {tx_negative_rail_data, tx_positive_rail_data,
                                                 tx_capture_edge_select, tx_line_clock,
                                                 transmitter_on_input};

    // Reset holds the transmitter-on view low, so an undriven input reads as off
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
            clk_s3_q <= 1'b0;
        end else begin
            pin_s1_q <= pin_raw;
            pin_s2_q <= pin_s1_q;
            clk_s3_q <= pin_s2_q[tx_capture_pkg::PIN_CLK];
        end
    end

    wire on_s   = pin_s2_q[tx_capture_pkg::PIN_ON];
    wire clk_s  = pin_s2_q[tx_capture_pkg::PIN_CLK];
    wire edge_s = pin_s2_q[tx_capture_pkg::PIN_EDGE];
    wire pos_s  = pin_s2_q[tx_capture_pkg::PIN_POS];
    wire neg_s  = pin_s2_q[tx_capture_pkg::PIN_NEG];

    // ---------------- Control register ----------------
    logic [tx_capture_pkg::CTRL_W-1:0] ctrl_q;
    logic [tx_capture_pkg::CTRL_W-1:0] ctrl_d;
    wire host_mode  = ctrl_q[tx_capture_pkg::CTRL_HOST_MODE_BIT];
    wire reg_rising = ctrl_q[tx_capture_pkg::CTRL_CAPTURE_RISING_BIT];
    wire dual_rail  = ctrl_q[tx_capture_pkg::CTRL_DUAL_RAIL_BIT];
    wire host_tx_en = ctrl_q[tx_capture_pkg::CTRL_HOST_TX_EN_BIT];

    // ---------------- Capture edge and rails ----------------
    wire clk_rise    = clk_s & ~clk_s3_q;
    wire clk_fall    = ~clk_s & clk_s3_q;
    // Pin choice is ignored in host mode since the pin then carries the serial clock
    wire edge_rising = host_mode ? reg_rising : edge_s;
    wire cap_evt     = edge_rising ? clk_rise : clk_fall;
    wire pos_bit     = pos_s;
    wire neg_bit     = dual_rail ? neg_s : 1'b0;

    // ---------------- Transmitter enable ----------------
    // Pin gates the outputs in both modes; host bit only adds a second off switch
    wire tx_en = on_s & (host_mode ? host_tx_en : 1'b1);

    logic tip_q;
    logic ring_q;
    logic oe_q;
    logic sclk_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            oe_q   <= 1'b0;
            tip_q  <= 1'b0;
            ring_q <= 1'b0;
            sclk_q <= 1'b0;
        end else begin
            oe_q   <= tx_en;
            tip_q  <= tx_en ? (cap_evt ? pos_bit : tip_q) : 1'b0;
            // Single rail parks the ring low so a stale dual-rail bit cannot linger
            ring_q <= (tx_en & dual_rail) ? (cap_evt ? neg_bit : ring_q) : 1'b0;
            sclk_q <= host_mode & edge_s;
        end
    end

    assign line_out_tip      = tip_q;
    assign line_out_ring     = ring_q;
    assign line_out_tip_oe   = oe_q;
    assign line_out_ring_oe  = oe_q;
    assign host_serial_clock = sclk_q;

    // ---------------- Capture buffer ----------------
    // The line clock cannot be stalled, so a full buffer drops the word and flags it
    logic buf_in_ready;
    logic [tx_capture_pkg::RAIL_W-1:0] buf_out_data;

    rail_skid_buffer #(
        .WIDTH (tx_capture_pkg::RAIL_W),
        .DEPTH (DEPTH)
    ) u_buf (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .in_valid  (cap_evt),
        .in_data   ({pos_bit, neg_bit}),
        .in_ready  (buf_in_ready),
        .out_valid (cap_valid),
        .out_data  (buf_out_data),
        .out_ready (cap_ready)
    );

    assign cap_pos_rail = buf_out_data[1];
    assign cap_neg_rail = buf_out_data[0];

    wire  ovf_set = cap_evt & ~buf_in_ready;
    logic ovf_q;
    logic [31:0] cnt_q;

    // ---------------- AXI4-Lite write path ----------------
    logic              aw_full_q;
    logic              w_full_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0]       wdata_q;
    logic [3:0]        wstrb_q;
    logic              awready_q;
    logic              wready_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    tx_capture_pkg::bus_state_e wr_state_q;

    wire aw_hs    = s_axi_awvalid & awready_q;
    wire w_hs     = s_axi_wvalid & wready_q;
    wire do_write = aw_full_q & w_full_q & (wr_state_q == tx_capture_pkg::BUS_IDLE);
    wire wr_ctrl  = do_write & addr_is(awaddr_q, tx_capture_pkg::CTRL_OFFSET);
    wire wr_stat  = do_write & addr_is(awaddr_q, tx_capture_pkg::STATUS_OFFSET);
    wire wr_cnt   = do_write & addr_is(awaddr_q, tx_capture_pkg::COUNT_OFFSET);
    wire wr_hit   = wr_ctrl | wr_stat | wr_cnt;
    wire ovf_clr  = wr_stat & wstrb_q[0] & wdata_q[tx_capture_pkg::STAT_OVERFLOW_BIT];
    wire aw_full_d = do_write ? 1'b0 : (aw_full_q | aw_hs);
    wire w_full_d  = do_write ? 1'b0 : (w_full_q | w_hs);
    wire bvalid_d  = bvalid_q ? ~s_axi_bready : do_write;

    assign ctrl_d = (wr_ctrl & wstrb_q[0]) ? wdata_q[tx_capture_pkg::CTRL_W-1:0] : ctrl_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            awaddr_q  <= '0;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
        end else begin
            aw_full_q <= aw_full_d;
            w_full_q  <= w_full_d;
            awaddr_q  <= aw_hs ? s_axi_awaddr : awaddr_q;
            wdata_q   <= w_hs ? s_axi_wdata : wdata_q;
            wstrb_q   <= w_hs ? s_axi_wstrb : wstrb_q;
            awready_q <= ~aw_full_d & ~bvalid_d;
            wready_q  <= ~w_full_d & ~bvalid_d;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_q <= tx_capture_pkg::BUS_IDLE;
            bvalid_q   <= 1'b0;
            bresp_q    <= tx_capture_pkg::RESP_OKAY;
        end else begin
            case (wr_state_q)
                tx_capture_pkg::BUS_IDLE: begin
                    if (do_write) begin
                        wr_state_q <= tx_capture_pkg::BUS_RESP;
                        bresp_q    <= wr_hit ? tx_capture_pkg::RESP_OKAY : tx_capture_pkg::RESP_SLVERR;
                    end
                end
                tx_capture_pkg::BUS_RESP: begin
                    if (s_axi_bready) begin
                        wr_state_q <= tx_capture_pkg::BUS_IDLE;
                    end
                end
                default: begin
                    wr_state_q <= tx_capture_pkg::BUS_IDLE;
                end
            endcase
            bvalid_q <= bvalid_d;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;

    // ---------------- Register state ----------------
    // A new overflow beats a clear written in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= tx_capture_pkg::CTRL_RESET;
            ovf_q  <= 1'b0;
            cnt_q  <= 32'h0000_0000;
        end else begin
            ctrl_q <= ctrl_d;
            ovf_q  <= ovf_set | (ovf_q & ~ovf_clr);
            cnt_q  <= (cap_evt & buf_in_ready) ? cnt_q + 32'h0000_0001 : cnt_q;
        end
    end

    // ---------------- AXI4-Lite read path ----------------
    logic        arready_q;
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    tx_capture_pkg::bus_state_e rd_state_q;

    wire ar_hs   = s_axi_arvalid & arready_q;
    wire rd_ctrl = addr_is(s_axi_araddr, tx_capture_pkg::CTRL_OFFSET);
    wire rd_stat = addr_is(s_axi_araddr, tx_capture_pkg::STATUS_OFFSET);
    wire rd_cnt  = addr_is(s_axi_araddr, tx_capture_pkg::COUNT_OFFSET);
    wire [tx_capture_pkg::STAT_W-1:0] stat_bits = {edge_rising, ovf_q, oe_q};
    wire [31:0] ctrl_word = {{(32-tx_capture_pkg::CTRL_W){1'b0}}, ctrl_q};
    wire [31:0] stat_word = {{(32-tx_capture_pkg::STAT_W){1'b0}}, stat_bits};
    wire [31:0] rd_word   = rd_ctrl ? ctrl_word : rd_stat ? stat_word : rd_cnt ? cnt_q : 32'h0000_0000;
    wire [1:0]  rd_resp   = (rd_ctrl | rd_stat | rd_cnt) ? tx_capture_pkg::RESP_OKAY : tx_capture_pkg::RESP_SLVERR;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state_q <= tx_capture_pkg::BUS_IDLE;
            arready_q  <= 1'b0;
            rvalid_q   <= 1'b0;
            rdata_q    <= 32'h0000_0000;
            rresp_q    <= tx_capture_pkg::RESP_OKAY;
        end else begin
            case (rd_state_q)
                tx_capture_pkg::BUS_IDLE: begin
                    arready_q <= ~ar_hs;
                    if (ar_hs) begin
                        rd_state_q <= tx_capture_pkg::BUS_RESP;
                        rvalid_q   <= 1'b1;
                        rdata_q    <= rd_word;
                        rresp_q    <= rd_resp;
                    end
                end
                tx_capture_pkg::BUS_RESP: begin
                    if (s_axi_rready) begin
                        rd_state_q <= tx_capture_pkg::BUS_IDLE;
                        rvalid_q   <= 1'b0;
                        arready_q  <= 1'b1;
                    end
                end
                default: begin
                    rd_state_q <= tx_capture_pkg::BUS_IDLE;
                    rvalid_q   <= 1'b0;
                    arready_q  <= 1'b0;
                end
            endcase
        end
    end

    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    // ---------------- Assertions ----------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_tx_on_drive: assert property (on_s && !host_mode |=> line_out_tip_oe && line_out_ring_oe)
        else $error("transmitter not enabled with on input high in pin mode");
    a_host_pin_gate: assert property (host_mode && !on_s |=> !line_out_tip_oe)
        else $error("on input low failed to disable transmitter in host mode");
    a_host_both_on: assert property (host_mode && host_tx_en && on_s |=> line_out_ring_oe)
        else $error("host mode transmitter not enabled with pin and bit high");
    a_off_hiz: assert property (!tx_en |=> !line_out_tip_oe && !line_out_ring_oe && !line_out_tip && !line_out_ring)
        else $error("line outputs still driven with transmitter off");
    a_reset_off: assert property (@(posedge aclk) disable iff (1'b0) !aresetn |=> !line_out_tip_oe)
        else $error("transmitter enabled right after reset");
    a_pin_rising: assert property (!host_mode && edge_s && clk_rise |-> cap_evt)
        else $error("rising edge capture missed in pin mode");
    a_pin_falling: assert property (!host_mode && !edge_s && $fell(clk_s) |-> cap_evt)
        else $error("falling edge capture missed in pin mode");
    a_host_edge_bit: assert property (host_mode && !reg_rising && clk_rise |-> !cap_evt)
        else $error("host mode captured on rising edge with falling selected");
    a_host_sclk: assert property (host_mode ##1 host_mode |-> host_serial_clock == $past(edge_s))
        else $error("serial clock does not follow the shared pin in host mode");
    a_pos_sample: assert property (cap_evt && tx_en |=> line_out_tip == $past(pos_s))
        else $error("positive rail not taken on the selected edge");
    a_neg_dual: assert property (cap_evt && tx_en && dual_rail |=> line_out_ring == $past(neg_s))
        else $error("negative rail not taken on the selected edge");
    a_neg_single: assert property (!dual_rail && tx_en ##1 !dual_rail |-> !line_out_ring)
        else $error("negative rail drove line in single rail mode");
    a_bresp_time: assert property (aw_full_q && w_full_q && !bvalid_q |=> s_axi_bvalid)
        else $error("write response late");
    a_ovf_set_wins: assert property (ovf_set |=> ovf_q)
        else $error("overflow flag lost on a dropped word");
    a_cap_hold: assert property (cap_valid && !cap_ready |=> cap_valid && $stable({cap_pos_rail, cap_neg_rail}))
        else $error("captured word changed while stalled");

    c_rise_capture: cover property (!host_mode && edge_s && clk_rise ##1 line_out_tip_oe);
    c_fall_capture: cover property (!host_mode && !edge_s && clk_fall && tx_en);
    c_host_capture: cover property (host_mode && reg_rising && clk_rise && tx_en);
    c_overflow:     cover property (ovf_set);
    c_single_rail:  cover property (!dual_rail && cap_evt && tx_en);

endmodule : tx_input_capture_ctrl
`default_nettype wire

// file: testbench/term_model.sv
// Terminal-side model driving the transmit clock and both data rails
`timescale 1ns/1ps
`default_nettype none
module term_model (
    output logic tx_line_clock,
    output logic pos_rail,
    output logic neg_rail
);
    initial begin
        tx_line_clock = 1'b0;
        pos_rail      = 1'b0;
        neg_rail      = 1'b0;
    end
    // Value a stands around the rising edge and value b around the falling edge, 31.25 ns margins
    task automatic send(input logic ap, input logic an, input logic bp, input logic bn);
        pos_rail = ap;
        neg_rail = an;
        #31.25 tx_line_clock = 1'b1;
        #31.25 pos_rail = bp;
        neg_rail = bn;
        #31.25 tx_line_clock = 1'b0;
        #31.25;
    endtask : send
    // Clock stands low between frames, so released rails toggle rather than hold
    task automatic idle();
        pos_rail = ~pos_rail;
        neg_rail = ~neg_rail;
    endtask : idle
endmodule : term_model
`default_nettype wire

// file: testbench/tb.sv
// Self-checking bench for the transmit input capture stage
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [3:0]  s_axi_awaddr = 4'h0;
    logic [3:0]  s_axi_araddr = 4'h0;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        transmitter_on_input = 1'b0, tx_capture_edge_select = 1'b0, cap_ready = 1'b0;
    wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire logic [1:0]  s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    wire logic   tx_line_clock, tx_positive_rail_data, tx_negative_rail_data, host_serial_clock;
    wire logic   line_out_tip, line_out_tip_oe, line_out_ring, line_out_ring_oe;
    wire logic   cap_valid, cap_pos_rail, cap_neg_rail;
    int          num_errors = 0, checked = 0, seed = 72, exp_count = 0;
    logic        stall = 1'b0, exp_ovf = 1'b0;
    logic [1:0]  exp_q[$];
    logic [1:0]  last_w = 2'h0;

    always #5 aclk = ~aclk;

    tx_input_capture_ctrl i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .transmitter_on_input, .tx_line_clock, .tx_capture_edge_select, .tx_positive_rail_data,
        .tx_negative_rail_data, .line_out_tip, .line_out_tip_oe, .line_out_ring, .line_out_ring_oe,
        .host_serial_clock, .cap_valid, .cap_pos_rail, .cap_neg_rail, .cap_ready);

    term_model i_term (.tx_line_clock, .pos_rail(tx_positive_rail_data), .neg_rail(tx_negative_rail_data));

    task automatic final_report();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic timeout(input int n);
        if (n >= 500) begin
            num_errors++;
            final_report();
        end
    endtask : timeout

    task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 500);
        s_axi_bready <= 1'b0;
        timeout(n);
        check(32'(s_axi_bresp), 32'(er));
    endtask : axi_write

    task automatic axi_read(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 500);
        s_axi_rready <= 1'b0;
        timeout(n);
        check(s_axi_rdata, exp);
        check(32'(s_axi_rresp), 32'(er));
    endtask : axi_read

    // Pin changes take three edges to reach the outputs
    task automatic pins(input logic on, input logic sel);
        @(posedge aclk);
        transmitter_on_input <= on;
        tx_capture_edge_select <= sel;
        repeat (4) @(posedge aclk);
    endtask : pins

    task automatic frame(input int n, input logic rising, input logic single);
        logic ap, an, bp, bn;
        logic [1:0] w;
        // Start off the aclk grid so no rail or link clock change lands on a sampling edge
        #1;
        repeat (n) begin
            {ap, an, bp, bn} = 4'($random(seed));
            w = rising ? {ap, an} : {bp, bn};
            if (single) w[0] = 1'b0;
            if (stall && exp_q.size() >= 2) exp_ovf = 1'b1;
            else begin
                exp_q.push_back(w);
                exp_count++;
            end
            last_w = w;
            i_term.send(ap, an, bp, bn);
        end
        i_term.idle();
    endtask : frame

    task automatic drain();
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < 500) begin
            @(posedge aclk);
            n++;
        end
        timeout(n);
        repeat (2) @(posedge aclk);
        if (!stall) check(32'({line_out_tip, line_out_ring}), 32'(last_w));
    endtask : drain

    always @(posedge aclk) begin
        cap_ready <= stall ? 1'b0 : 1'($random(seed));
        if (aresetn && cap_valid && cap_ready) begin
            if (exp_q.size() == 0) check(32'(cap_valid), 32'h0000_0000);
            else check(32'({cap_pos_rail, cap_neg_rail}), 32'(exp_q.pop_front()));
        end
    end

    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(tx_capture_pkg::CTRL_OFFSET, 32'h0000_0004, tx_capture_pkg::RESP_OKAY);
        axi_read(tx_capture_pkg::STATUS_OFFSET, 32'h0000_0000, tx_capture_pkg::RESP_OKAY);
        axi_write(4'hc, 32'h0000_00ff, tx_capture_pkg::RESP_SLVERR);
        axi_read(4'hc, 32'h0000_0000, tx_capture_pkg::RESP_SLVERR);
        pins(1'b1, 1'b1);
        check(32'({line_out_tip_oe, line_out_ring_oe}), 32'h0000_0003);
        frame(6, 1'b1, 1'b0);
        drain();
        pins(1'b1, 1'b0);
        frame(6, 1'b0, 1'b0);
        drain();
        axi_write(tx_capture_pkg::CTRL_OFFSET, 32'h0000_0000, tx_capture_pkg::RESP_OKAY);
        frame(5, 1'b0, 1'b1);
        drain();
        axi_write(tx_capture_pkg::CTRL_OFFSET, 32'h0000_000f, tx_capture_pkg::RESP_OKAY);
        frame(5, 1'b1, 1'b0);
        drain();
        pins(1'b1, 1'b1);
        check(32'(host_serial_clock), 32'h0000_0001);
        axi_write(tx_capture_pkg::CTRL_OFFSET, 32'h0000_000d, tx_capture_pkg::RESP_OKAY);
        frame(5, 1'b0, 1'b0);
        drain();
        axi_write(tx_capture_pkg::CTRL_OFFSET, 32'h0000_0005, tx_capture_pkg::RESP_OKAY);
        pins(1'b1, 1'b0);
        check(32'({line_out_tip, line_out_tip_oe, line_out_ring, line_out_ring_oe}), 32'h0000_0000);
        check(32'(host_serial_clock), 32'h0000_0000);
        axi_read(tx_capture_pkg::STATUS_OFFSET, 32'h0000_0000, tx_capture_pkg::RESP_OKAY);
        axi_write(tx_capture_pkg::CTRL_OFFSET, 32'h0000_000d, tx_capture_pkg::RESP_OKAY);
        pins(1'b0, 1'b1);
        check(32'({line_out_tip_oe, line_out_ring_oe}), 32'h0000_0000);
        axi_write(tx_capture_pkg::CTRL_OFFSET, 32'h0000_0004, tx_capture_pkg::RESP_OKAY);
        pins(1'b1, 1'b1);
        check(32'({line_out_tip_oe, line_out_ring_oe}), 32'h0000_0003);
        stall <= 1'b1;
        frame(4, 1'b1, 1'b0);
        axi_read(tx_capture_pkg::STATUS_OFFSET, {29'h0000_0000, 1'b1, exp_ovf, 1'b1}, tx_capture_pkg::RESP_OKAY);
        stall <= 1'b0;
        drain();
        axi_write(tx_capture_pkg::STATUS_OFFSET, 32'h0000_0002, tx_capture_pkg::RESP_OKAY);
        axi_read(tx_capture_pkg::STATUS_OFFSET, 32'h0000_0005, tx_capture_pkg::RESP_OKAY);
        axi_write(tx_capture_pkg::COUNT_OFFSET, 32'hffff_ffff, tx_capture_pkg::RESP_OKAY);
        axi_read(tx_capture_pkg::COUNT_OFFSET, 32'(exp_count), tx_capture_pkg::RESP_OKAY);
        final_report();
    end
endmodule : tb
`default_nettype wire
